//--- core/ivm_params.svh
// Purpose: Constants for the interrupt vector mapper.
// Assumes: 20-bit addresses, byte-wide vector memory.
// Notes:   Definitions only.
`ifndef IVM_PARAMS_SVH
`define IVM_PARAMS_SVH
`define IVM_FIX_UND      20'hfffdc
`define IVM_FIX_OVF      20'hfffe0
`define IVM_FIX_BRK      20'hfffe4
`define IVM_FIX_AMATCH   20'hfffe8
`define IVM_FIX_SSTEP    20'hfffec
`define IVM_FIX_WDOG     20'hffff0
`define IVM_FIX_DBRK     20'hffff4
`define IVM_FIX_DBGRX    20'hffff8
`define IVM_FIX_RESET    20'hffffc
`define IVM_FIX_LOW      20'hfffdc
`define IVM_BRK_EMPTY    8'hff
`define IVM_NUM_SRC      32
`define IVM_MASKABLE_TOP 6'h1f
`define IVM_NMI_SW_LOW   6'h20
`define IVM_BRK_NUM      6'h00
`define IVM_NUM_KEY      5'h0d
`define IVM_NUM_CNTR     5'h19
`define IVM_NUM_CAPT     5'h1a
`define IVM_NUM_EXT3     5'h1c
`define IVM_NUM_EXT0     5'h1d
`define IVM_NUM_EXT1     5'h1e
`define IVM_NUM_EXT2     5'h1f
`define IVM_EDGE_FALL    2'h0
`define IVM_EDGE_RISE    2'h1
`define IVM_EDGE_BOTH    2'h2
`endif

//--- core/ivm_pkg.sv
// Purpose: Types for the interrupt vector mapper.
// Assumes: Included constants header.
// Notes:   Types only.
package ivm_pkg;
  typedef struct packed {
    logic        valid;
    logic [19:0] addr;
  } ivm_fetch_type;
  typedef struct packed {
    logic       is_fixed;
    logic [3:0] fixed_sel;
    logic [5:0] sw_num;
  } ivm_req_type;
endpackage

//--- core/ivm_edge_detect.sv
// Purpose: Synchronise one pin and detect a chosen edge.
// Assumes: Pin is asynchronous to i_mclk.
// Notes:   Mode codes come from the constants header.
`timescale 1ns/100ps
`default_nettype none
`include "ivm_params.svh"
module ivm_edge_detect (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_pin,
  input  wire logic [1:0] i_mode,
  output logic            o_hit
);
  logic s1;
  logic s2;
  logic s3;
  logic       next_hit;
  logic [2:0] warm;
  always_comb begin
    case (i_mode)
      `IVM_EDGE_FALL: next_hit = s3 & ~s2;
      `IVM_EDGE_RISE: next_hit = ~s3 & s2;
      `IVM_EDGE_BOTH: next_hit = s3 ^ s2;
      default:        next_hit = 1'b0;
    endcase
    // A pin that idles high would show a false edge while the stages fill after reset.
    if (!warm[2]) begin
      next_hit = 1'b0;
    end
  end
  // The first stage feeds only the second, to contain metastability.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      warm  <= 3'h0;
      o_hit <= 1'b0;
    end else begin
      s1    <= i_pin;
      s2    <= s1;
      s3    <= s2;
      warm  <= {warm[1:0], 1'b1};
      o_hit <= next_hit;
    end
  end
endmodule // ivm_edge_detect
`default_nettype wire

//--- core/ivm_mapper.sv
// Purpose: Map interrupt sources to vector addresses and fetch them.
// Assumes: Core reads vector bytes one at a time with one-cycle latency.
// Notes:   Source numbers 0..31 follow software interrupt numbering.
`timescale 1ns/100ps
`default_nettype none
`include "ivm_params.svh"
// Overview of operation
// - Peripheral interrupts obey enable flag, priority
// - Peripherals share software vectors 0 to 31
// - Key pin interrupts on either edge
// - Counter pin interrupts on either edge
// - Capture pin edges or ring source interrupt
// - External 0-2 rise, fall or both
// - External 3 falling or both only
// - Accepted request branches to vector address
// - Fixed vectors occupy top four-byte entries
// - Fixed vector base addresses per cause
// - Empty break vector uses variable entry
// - Variable entries at base plus four times number
// - Variable entry numbers per source
// - Break and traps 32-63 ignore enable
// - Level zero disables a maskable source
// - Each source has a pending bit
module ivm_mapper
  import ivm_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_key_input_pin,
  input  wire logic        i_counter_input_pin,
  input  wire logic        i_capture_input_pin,
  input  wire logic [1:0]  i_capture_mode,
  input  wire logic        i_ring_osc_divided_source,
  input  wire logic        i_external_irq_0,
  input  wire logic        i_external_irq_1,
  input  wire logic        i_external_irq_2,
  input  wire logic        i_external_irq_3,
  input  wire logic [5:0]  i_ext_polarity,
  input  wire logic [1:0]  i_ext3_mode,
  input  wire logic [31:0] i_periph_irq,
  input  wire logic [95:0] i_priority_level_field,
  input  wire logic [31:0] i_pending_clear,
  input  wire logic        i_enable_flag,
  input  wire logic [2:0]  i_core_level,
  input  wire logic [19:0] i_vector_base_reg,
  input  wire logic        i_sw_req,
  input  wire ivm_req_type i_sw_info,
  input  wire logic        i_core_ready,
  input  wire logic [7:0]  i_mem_rdata,
  output logic [31:0]      o_request_pending_bit,
  output logic             o_mem_rd,
  output logic [19:0]      o_mem_addr,
  output ivm_fetch_type    o_vector,
  output logic [5:0]       o_taken_num,
  output logic             o_busy
);
  // ------------------------------------------------------------
  // Pin edge detection
  // ------------------------------------------------------------
  logic [3:0] ext_hit;
  logic       key_hit;
  logic       cntr_hit;
  logic       capt_hit;
  logic [3:0] ext_pin;
  logic [7:0] ext_mode;
  logic       ring_s1;
  logic       ring_s2;
  logic       ring_s3;
  assign ext_pin = {i_external_irq_3, i_external_irq_2, i_external_irq_1, i_external_irq_0};
  ivm_edge_detect u_key (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_pin(i_key_input_pin),
    .i_mode(`IVM_EDGE_BOTH), .o_hit(key_hit));
  ivm_edge_detect u_cntr (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_pin(i_counter_input_pin),
    .i_mode(`IVM_EDGE_BOTH), .o_hit(cntr_hit));
  ivm_edge_detect u_capt (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_pin(i_capture_input_pin),
    .i_mode(i_capture_mode), .o_hit(capt_hit));
  assign ext_mode[5:0] = i_ext_polarity;
  // rising-only mode refused for external 3
  assign ext_mode[7:6] = (i_ext3_mode == `IVM_EDGE_BOTH) ? `IVM_EDGE_BOTH : `IVM_EDGE_FALL;
  for (genvar g = 0; g < 4; g++) begin : g_ext
    ivm_edge_detect u_ext (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_pin(ext_pin[g]),
      .i_mode(ext_mode[2*g+1 -: 2]), .o_hit(ext_hit[g]));
  end
  // ring source rising edge also raises capture
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ring_s1 <= 1'b0;
      ring_s2 <= 1'b0;
      ring_s3 <= 1'b0;
    end else begin
      ring_s1 <= i_ring_osc_divided_source;
      ring_s2 <= ring_s1;
      ring_s3 <= ring_s2;
    end
  end

  // ------------------------------------------------------------
  // Pending bits
  // ------------------------------------------------------------
  logic [31:0] src_event;
  logic [31:0] next_pending;
  logic [31:0] ack_mask;
  always_comb begin
    src_event = i_periph_irq;
    // pin sources at their entry numbers
    src_event[`IVM_NUM_KEY]  = key_hit;
    src_event[`IVM_NUM_CNTR] = cntr_hit;
    src_event[`IVM_NUM_CAPT] = capt_hit | (ring_s2 & ~ring_s3);
    src_event[`IVM_NUM_EXT0] = ext_hit[0];
    src_event[`IVM_NUM_EXT1] = ext_hit[1];
    src_event[`IVM_NUM_EXT2] = ext_hit[2];
    src_event[`IVM_NUM_EXT3] = ext_hit[3];
    // pending bits, set wins over clear
    next_pending = (o_request_pending_bit & ~i_pending_clear & ~ack_mask) | src_event;
  end

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  logic        win_valid;
  logic [4:0]  win_num;
  logic [2:0]  win_lvl;
  always_comb begin
    win_valid = 1'b0;
    win_num   = 5'h00;
    win_lvl   = 3'h0;
    for (int k = 0; k < `IVM_NUM_SRC; k++) begin
      // level zero disables; enable flag and level
      if (o_request_pending_bit[k] && i_enable_flag &&
          i_priority_level_field[3*k +: 3] != 3'h0 &&
          i_priority_level_field[3*k +: 3] > i_core_level &&
          (!win_valid || i_priority_level_field[3*k +: 3] > win_lvl)) begin
        win_valid = 1'b1;
        win_num   = 5'(k);
        win_lvl   = i_priority_level_field[3*k +: 3];
      end
    end
  end

  // ------------------------------------------------------------
  // Vector fetch sequencer
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_CHECK = 4'b0100,
    ST_DONE  = 4'b1000
  } ivm_state_type;
  ivm_state_type state;
  ivm_state_type next_state;
  logic [19:0]   base_addr;
  logic [19:0]   next_base_addr;
  logic [1:0]    byte_idx;
  logic [1:0]    next_byte_idx;
  logic [31:0]   vec;
  logic [31:0]   next_vec;
  logic          is_brk_fixed;
  logic          next_is_brk_fixed;
  logic          rd_d;
  logic          next_mem_rd;
  logic [19:0]   next_mem_addr;
  ivm_fetch_type next_vector;
  logic [5:0]    next_taken_num;
  logic [19:0]   fixed_addr;
  always_comb begin
    case (i_sw_info.fixed_sel)
      4'h0:    fixed_addr = `IVM_FIX_UND;
      4'h1:    fixed_addr = `IVM_FIX_OVF;
      4'h2:    fixed_addr = `IVM_FIX_BRK;
      4'h3:    fixed_addr = `IVM_FIX_AMATCH;
      4'h4:    fixed_addr = `IVM_FIX_SSTEP;
      4'h5:    fixed_addr = `IVM_FIX_WDOG;
      4'h6:    fixed_addr = `IVM_FIX_DBRK;
      4'h7:    fixed_addr = `IVM_FIX_DBGRX;
      default: fixed_addr = `IVM_FIX_RESET;
    endcase
  end
  always_comb begin
    next_state        = state;
    next_base_addr    = base_addr;
    next_byte_idx     = byte_idx;
    next_vec          = vec;
    next_is_brk_fixed = is_brk_fixed;
    next_mem_rd       = 1'b0;
    next_mem_addr     = o_mem_addr;
    next_vector       = '0;
    next_taken_num    = o_taken_num;
    ack_mask          = 32'h0;
    case (state)
      ST_IDLE: begin
        // software requests bypass the enable flag
        if (i_sw_req) begin
          next_state = ST_READ;
          if (i_sw_info.is_fixed) begin
            next_base_addr    = fixed_addr;
            next_is_brk_fixed = (i_sw_info.fixed_sel == 4'h2);
            next_taken_num    = `IVM_BRK_NUM;
          end else begin
            next_base_addr    = i_vector_base_reg + {12'h000, i_sw_info.sw_num, 2'b00};
            next_is_brk_fixed = 1'b0;
            next_taken_num    = i_sw_info.sw_num;
          end
        end else if (win_valid) begin
          next_state        = ST_READ;
          next_base_addr    = i_vector_base_reg + {13'h0000, win_num, 2'b00};
          next_is_brk_fixed = 1'b0;
          next_taken_num    = {1'b0, win_num};
          ack_mask[win_num] = 1'b1;
        end
        next_byte_idx = 2'h0;
        if (next_state == ST_READ) begin
          next_mem_rd   = 1'b1;
          next_mem_addr = next_base_addr;
        end
      end
      ST_READ: begin
        // low byte first, taken one cycle after its strobe
        if (rd_d) begin
          next_vec = {i_mem_rdata, vec[31:8]};
        end
        if (byte_idx == 2'h3) begin
          // The last byte lands only after its strobe has dropped.
          if (!o_mem_rd) begin
            next_state = ST_CHECK;
          end
        end else begin
          next_byte_idx = byte_idx + 2'h1;
          next_mem_rd   = 1'b1;
          next_mem_addr = base_addr + {18'h00000, next_byte_idx};
        end
      end
      ST_CHECK: begin
        // empty break vector redirects to variable entry
        if (is_brk_fixed && vec == {4{`IVM_BRK_EMPTY}}) begin
          next_state        = ST_READ;
          next_is_brk_fixed = 1'b0;
          next_base_addr    = i_vector_base_reg;
          next_byte_idx     = 2'h0;
          next_mem_rd       = 1'b1;
          next_mem_addr     = i_vector_base_reg;
        end else begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_vector.valid = 1'b1;
        next_vector.addr  = vec[19:0];
        if (i_core_ready) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state                 <= ST_IDLE;
      base_addr             <= 20'h00000;
      byte_idx              <= 2'h0;
      vec                   <= 32'h0;
      is_brk_fixed          <= 1'b0;
      rd_d                  <= 1'b0;
      o_mem_rd              <= 1'b0;
      o_mem_addr            <= 20'h00000;
      o_vector              <= '0;
      o_taken_num           <= 6'h00;
      o_busy                <= 1'b0;
      o_request_pending_bit <= 32'h0;
    end else begin
      state                 <= next_state;
      base_addr             <= next_base_addr;
      byte_idx              <= next_byte_idx;
      vec                   <= next_vec;
      is_brk_fixed          <= next_is_brk_fixed;
      rd_d                  <= o_mem_rd;
      o_mem_rd              <= next_mem_rd;
      o_mem_addr            <= next_mem_addr;
      o_vector              <= next_vector;
      o_taken_num           <= next_taken_num;
      o_busy                <= (next_state != ST_IDLE);
      o_request_pending_bit <= next_pending;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence fetch_start_s;
    state == ST_IDLE && next_state == ST_READ;
  endsequence
  pending_set_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    src_event[`IVM_NUM_KEY] |=> o_request_pending_bit[`IVM_NUM_KEY])
    else $error("Key event did not set pending bit.");
  level_zero_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (state == ST_IDLE && !i_sw_req && win_valid) |=>
    i_priority_level_field[3*o_taken_num[4:0] +: 3] != 3'h0)
    else $error("Level zero source was accepted.");
  enable_gate_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (state == ST_IDLE && !i_sw_req && !i_enable_flag) |=> state == ST_IDLE)
    else $error("Maskable taken with enable clear.");
  sw_unmasked_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (state == ST_IDLE && i_sw_req) |=> state == ST_READ)
    else $error("Software request blocked.");
  var_addr_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (state == ST_IDLE && !i_sw_req && win_valid) |=>
    o_mem_addr == $past(i_vector_base_reg) + {13'h0000, $past(win_num), 2'b00})
    else $error("Wrong variable vector address.");
  four_reads_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    fetch_start_s |=> o_mem_rd [*4])
    else $error("Vector not read as four bytes.");
  ext3_rise_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    ext_mode[7:6] != `IVM_EDGE_RISE)
    else $error("External 3 rising-only mode used.");
  done_vec_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (state == ST_DONE) |=> o_vector.valid && o_vector.addr == $past(vec[19:0]))
    else $error("Vector not presented.");
endmodule // ivm_mapper
`default_nettype wire

//--- verification/ivm_core_model.sv
// Purpose: Processor core and vector memory seen from the mapper.
// Assumes: One read strobe per byte, data one cycle after the strobe.
// Notes:   The idle data bus inverts its value every cycle.
`timescale 1ns/100ps
`default_nettype none
module ivm_core_model (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_mem_rd,
  input  wire logic [19:0] i_mem_addr,
  input  wire logic        i_valid,
  input  wire logic        i_brk_empty,
  input  wire logic        i_slow,
  output logic [7:0]       o_mem_rdata,
  output logic             o_core_ready
);
  logic [3:0] wait_cnt;

  function automatic logic [7:0] mem_byte(input logic [19:0] a);
    if (i_brk_empty && a[19:2] == 18'h3fff9) return 8'hff;
    return a[7:0] + a[15:8] + 8'h3c;
  endfunction

  // ---------------------------------------------------------------
  // Memory and core answer
  // ---------------------------------------------------------------
  // The slow core makes the mapper hold its vector for several cycles.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_rdata  <= 8'h00;
      o_core_ready <= 1'b0;
      wait_cnt     <= 4'h0;
    end else begin
      o_mem_rdata  <= i_mem_rd ? mem_byte(i_mem_addr) : ~o_mem_rdata;
      wait_cnt     <= i_valid ? wait_cnt + 4'h1 : 4'h0;
      o_core_ready <= i_valid && (wait_cnt >= (i_slow ? 4'h6 : 4'h0));
    end
  end
endmodule // ivm_core_model
`default_nettype wire

//--- verification/tb_interrupt_vector_mapper.sv
// Purpose: Self-checking bench for the interrupt vector mapper.
// Assumes: The core model answers each byte read one cycle later.
// Notes:   Pins are bits of one vector: key, counter, capture, ring, ext0-3.
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_vector_mapper
  import ivm_pkg::*;
;
  typedef struct packed {
    ivm_req_type req;
    logic [19:0] a0;
    logic [5:0]  num;
  } ivm_row_type;
  localparam logic [19:0] vec_base = 20'h2a500;
  logic          i_mclk, i_resetn, i_enable_flag, i_sw_req, i_core_ready;
  logic          o_mem_rd, o_busy, brk_empty, slow;
  logic [7:0]    pins, i_mem_rdata;
  logic [1:0]    i_capture_mode, i_ext3_mode;
  logic [5:0]    i_ext_polarity, o_taken_num;
  logic [31:0]   i_periph_irq, i_pending_clear, o_request_pending_bit;
  logic [95:0]   i_priority_level_field;
  logic [2:0]    i_core_level;
  logic [19:0]   i_vector_base_reg, o_mem_addr;
  ivm_req_type   i_sw_info;
  ivm_fetch_type o_vector;
  int            errors, comparisons;
  // table rows; codes 4, 6 and 7 serve the debugger only.
  ivm_row_type rows [10] = '{
    '{'{1'b1, 4'h0, 6'h00}, 20'hfffdc, 6'h00},
    '{'{1'b1, 4'h1, 6'h00}, 20'hfffe0, 6'h00},
    '{'{1'b1, 4'h2, 6'h00}, 20'hfffe4, 6'h00},
    '{'{1'b1, 4'h3, 6'h00}, 20'hfffe8, 6'h00},
    '{'{1'b1, 4'h5, 6'h00}, 20'hffff0, 6'h00},
    '{'{1'b1, 4'h8, 6'h00}, 20'hffffc, 6'h00},
    '{'{1'b0, 4'h0, 6'h00}, vec_base, 6'h00},
    '{'{1'b0, 4'h0, 6'h1f}, vec_base + 20'h0007c, 6'h1f},
    '{'{1'b0, 4'h0, 6'h20}, vec_base + 20'h00080, 6'h20},
    '{'{1'b0, 4'h0, 6'h3f}, vec_base + 20'h000fc, 6'h3f}};

  ivm_mapper ivm_mapper_inst (.i_mclk, .i_resetn, .i_key_input_pin(pins[0]),
    .i_counter_input_pin(pins[1]), .i_capture_input_pin(pins[2]), .i_capture_mode,
    .i_ring_osc_divided_source(pins[3]), .i_external_irq_0(pins[4]),
    .i_external_irq_1(pins[5]), .i_external_irq_2(pins[6]), .i_external_irq_3(pins[7]),
    .i_ext_polarity, .i_ext3_mode, .i_periph_irq, .i_priority_level_field,
    .i_pending_clear, .i_enable_flag, .i_core_level, .i_vector_base_reg, .i_sw_req,
    .i_sw_info, .i_core_ready, .i_mem_rdata, .o_request_pending_bit, .o_mem_rd,
    .o_mem_addr, .o_vector, .o_taken_num, .o_busy);
  ivm_core_model ivm_core_model_inst (.i_mclk, .i_resetn, .i_mem_rd(o_mem_rd),
    .i_mem_addr(o_mem_addr), .i_valid(o_vector.valid), .i_brk_empty(brk_empty),
    .i_slow(slow), .o_mem_rdata(i_mem_rdata), .o_core_ready(i_core_ready));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  task automatic tick;
    @(posedge i_mclk);
    #2;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [19:0] vec(input logic [19:0] a);
    logic [7:0] b [3];
    foreach (b[i]) b[i] = a[7:0] + 8'(i) + a[15:8] + 8'h3c;
    return {b[2][3:0], b[1], b[0]};
  endfunction

  task automatic fetch(input logic [19:0] a0, input logic [19:0] a1, input logic [5:0] num);
    int k;
    int n;
    k = 0;
    n = 0;
    while (o_vector.valid !== 1'b1 && n < 60) begin
      if (o_mem_rd === 1'b1) begin
        check(o_mem_addr, k < 4 ? a0 + 20'(k) : a1 + 20'(k - 4));
        k++;
      end
      tick;
      n++;
    end
    check(k, a0 == a1 ? 4 : 8);
    check(o_vector.addr, vec(a1));
    check(o_taken_num, num);
    while (o_busy !== 1'b0 && n < 90) begin
      tick;
      n++;
    end
    check(o_vector.valid, 1'b1);
    tick;
    check(o_vector.valid, 1'b0);
  endtask

  task automatic vfetch(input logic [5:0] e);
    fetch(vec_base + {12'h000, e, 2'h0}, vec_base + {12'h000, e, 2'h0}, e);
  endtask

  task automatic sw(input ivm_req_type r);
    tick;
    i_sw_info = r;
    i_sw_req  = 1'b1;
    tick;
    i_sw_req  = 1'b0;
  endtask

  task automatic pin(input int idx, input logic v, input logic [5:0] e);
    tick;
    pins[idx] = v;
    vfetch(e);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  // About 30 times the expected run length, so a hang ends the run early.
  initial begin
    #400000;
    errors++;
    results;
  end

  initial begin
    {i_resetn, i_enable_flag, i_sw_req, brk_empty, slow} = 5'h00;
    {i_periph_irq, i_pending_clear, i_priority_level_field} = 160'h0;
    {i_capture_mode, i_core_level, i_sw_info} = 16'h0000;
    pins              = 8'hc0;
    i_ext_polarity    = 6'h09;
    i_ext3_mode       = 2'h2;
    i_vector_base_reg = vec_base;
    repeat (8) tick;
    check({o_busy, o_mem_rd, o_vector, o_request_pending_bit[7:0]}, 32'h0);
    i_resetn = 1'b1;
    repeat (6) tick;
    check(o_request_pending_bit[28], 1'b0);
    i_ext3_mode = 2'h1;
    foreach (rows[i]) begin
      slow = 1'(i % 2);
      sw(rows[i].req);
      fetch(rows[i].a0, rows[i].a0, rows[i].num);
    end
    brk_empty = 1'b1;
    sw('{1'b1, 4'h2, 6'h00});
    fetch(20'hfffe4, vec_base, 6'h00);
    brk_empty = 1'b0;
    i_periph_irq[17] = 1'b1;
    tick;
    i_periph_irq = 32'h0;
    repeat (6) tick;
    check({o_busy, o_request_pending_bit[17]}, 2'h1);
    i_priority_level_field[51 +: 3] = 3'h3;
    repeat (6) tick;
    check({o_busy, o_request_pending_bit[17]}, 2'h1);
    i_enable_flag = 1'b1;
    vfetch(6'h11);
    check(o_request_pending_bit[17], 1'b0);
    i_periph_irq[18] = 1'b1;
    tick;
    i_periph_irq    = 32'h0;
    i_pending_clear = 32'h00040000;
    tick;
    i_pending_clear = 32'h0;
    tick;
    check({o_busy, o_request_pending_bit[18]}, 2'h0);
    i_priority_level_field[42 +: 3] = 3'h2;
    i_priority_level_field[63 +: 3] = 3'h5;
    i_core_level = 3'h4;
    i_periph_irq = 32'h00204000;
    tick;
    i_periph_irq = 32'h0;
    vfetch(6'h15);
    repeat (4) tick;
    check(o_busy, 1'b0);
    i_core_level = 3'h0;
    vfetch(6'h0e);
    i_priority_level_field = {32{3'h1}};
    pin(0, 1'b1, 6'h0d);
    pin(0, 1'b0, 6'h0d);
    pin(1, 1'b1, 6'h19);
    i_capture_mode = 2'h1;
    pin(2, 1'b1, 6'h1a);
    i_capture_mode = 2'h0;
    pin(2, 1'b0, 6'h1a);
    pin(3, 1'b1, 6'h1a);
    pin(4, 1'b1, 6'h1d);
    pin(5, 1'b1, 6'h1e);
    pin(5, 1'b0, 6'h1e);
    pin(6, 1'b0, 6'h1f);
    pin(7, 1'b0, 6'h1c);
    pins[7] = 1'b1;
    repeat (8) tick;
    check({o_busy, o_request_pending_bit[28]}, 2'h0);
    i_ext3_mode = 2'h2;
    pin(7, 1'b0, 6'h1c);
    pin(7, 1'b1, 6'h1c);
    results;
  end
endmodule // tb_interrupt_vector_mapper
`default_nettype wire
